// [sdpi_pkg.sv]
package sdpi_pkg;

  // Clock rate of the returned memory clock domain and the nominal outgoing memory clock
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned MCLK_OUT_MHZ = 66;
  // Half period of the outgoing clock in core cycles, rounded down, never below one
  localparam int unsigned MCLK_HALF_RAW = CLK_MHZ / (2 * MCLK_OUT_MHZ);
  localparam int unsigned MCLK_HALF     = (MCLK_HALF_RAW < 1) ? 1 : MCLK_HALF_RAW;
  localparam int unsigned MCLK_CNT_W    = 4;

  // Field widths and positions of the memory pins
  localparam int unsigned DATA_W   = 64;
  localparam int unsigned LANES    = 8;
  localparam int unsigned ADDR_W   = 11;
  localparam int unsigned ROW_W    = 13;
  localparam int unsigned ROW_B11  = 11;
  localparam int unsigned ROW_B12  = 12;
  localparam int unsigned STRAP_W  = 41;

  // Memory density selection for the two shared pins
  localparam logic [1:0] DENS_16M   = 2'h0;
  localparam logic [1:0] DENS_2BANK = 2'h1;
  localparam logic [1:0] DENS_4BANK = 2'h2;

  // Values after reset
  localparam logic [LANES-1:0]   MASK_IDLE  = 8'hff;
  localparam logic [STRAP_W-1:0] STRAP_RST  = 41'h000_0000_0000;
  localparam logic [ADDR_W-1:0]  ADDR_RST   = 11'h000;

  // Access sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_STALL = 5'h02,
    ST_ROW   = 5'h04,
    ST_COL   = 5'h08,
    ST_DATA  = 5'h10
  } sdpi_state_e;

endpackage

// [sdpi_buf.sv]
`timescale 1ns/1ps
// Two-entry buffer: head register drives the output, spare catches a word during a stall
module sdpi_buf #(
  parameter int unsigned WIDTH = 64
) (
  input  wire logic             clk,       // Core clock
  input  wire logic             rst,       // Synchronous reset
  input  wire logic             ce,        // Clock enable
  input  wire logic             in_valid,  // Word offered
  output logic                  in_ready,  // Space for a word
  input  wire logic [WIDTH-1:0] in_data,   // Word in
  output logic                  out_valid, // Head word valid
  input  wire logic             out_ready, // Receiver takes head
  output logic      [WIDTH-1:0] out_data   // Head word
);

  logic             spare_v;
  logic [WIDTH-1:0] spare;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Ready comes from the spare flag so the filling side never sees a combinational path
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      spare_v   <= 1'b0;
      in_ready  <= 1'b1;
      out_data  <= '0;
      spare     <= '0;
    end else if (ce) begin
      if (pop || !out_valid) begin
        out_valid <= spare_v | push;
        out_data  <= spare_v ? spare : in_data;
        spare_v   <= spare_v & push;
        in_ready  <= 1'b1;
        if (spare_v) begin
          spare <= in_data;
        end
      end else if (push) begin
        spare_v  <= 1'b1;
        spare    <= in_data;
        in_ready <= 1'b0;
      end
    end
  end

endmodule // sdpi_buf

// [sdpi_top.sv]
`timescale 1ns/1ps
module sdpi_top (
  input  wire logic                          clk,             // Returned memory clock
  input  wire logic                          rst,             // Synchronous reset
  input  wire logic                          ce,              // Clock enable
  input  wire logic                          sys_reset_in_n,  // Async system reset in
  output logic                               sys_reset_out_n, // Reset to the system
  output logic                               hard_reset,      // Hard reset start pulse
  output logic [sdpi_pkg::STRAP_W-1:0]       strap,           // Strap options
  output logic                               mem_clk_out,     // Clock to the DIMMs
  input  wire logic [1:0]                    density,         // Device density select
  input  wire logic                          req_valid,       // Access request
  output logic                               req_ready,       // Request taken when high
  input  wire logic                          req_write,       // 1 write, 0 read
  input  wire logic [1:0]                    req_chip,        // Chip select index
  input  wire logic [1:0]                    req_bank,        // Bank address
  input  wire logic [sdpi_pkg::ROW_W-1:0]    req_row,         // Row address
  input  wire logic [sdpi_pkg::ADDR_W-1:0]   req_col,         // Column address
  input  wire logic [sdpi_pkg::DATA_W-1:0]   req_wdata,       // Write data
  input  wire logic [sdpi_pkg::LANES-1:0]    req_mask,        // Lane mask, 1 masks
  output logic                               rd_valid,        // Read data valid
  input  wire logic                          rd_ready,        // Read data taken
  output logic [sdpi_pkg::DATA_W-1:0]        rd_data,         // Read data
  output logic [1:0]                         mem_cs_n,        // Chip selects 0 and 1
  output logic                               mem_cs2_a11,     // Select 2 or address 11
  output logic                               mem_cs3_a12_ba1, // Select 3, address 12 or bank 1
  output logic [sdpi_pkg::ADDR_W-1:0]        mem_addr,        // Row and column address
  output logic                               mem_ba0,         // Bank address 0
  output logic [1:0]                         mem_ras_n,       // Row strobes
  output logic [1:0]                         mem_cas_n,       // Column strobes
  output logic                               mem_write_en_n,  // Write enable
  output logic [sdpi_pkg::LANES-1:0]         mem_mask,        // Byte masks, 1 masks
  input  wire logic [sdpi_pkg::DATA_W-1:0]   mem_data_i,      // Data bus in
  output logic [sdpi_pkg::DATA_W-1:0]        mem_data_o,      // Data bus out
  output logic                               mem_data_oe      // Data bus drive enable
);

  // Reset input synchroniser; stage one is read only by stage two
  logic sync1;
  logic sync2;
  logic sync3;
  always_ff @(posedge clk) begin
    if (ce) begin
      sync1 <= sys_reset_in_n;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  wire reset_rise = sync2 & ~sync3;
  // Keep the sequencer idle while the system reset is held low
  wire int_rst    = rst | ~sync2;

  // Straps catch the data bus on the release edge and hold until the next one
  always_ff @(posedge clk) begin
    if (rst) begin
      strap           <= sdpi_pkg::STRAP_RST;
      hard_reset      <= 1'b0;
      sys_reset_out_n <= 1'b0;
    end else if (ce) begin
      hard_reset      <= reset_rise;
      sys_reset_out_n <= sync2;
      if (reset_rise) begin
        strap <= mem_data_i[sdpi_pkg::STRAP_W-1:0];
      end
    end
  end

  // Outgoing clock; the true part has a PLL, here a divider of the core clock stands in
  logic [sdpi_pkg::MCLK_CNT_W-1:0] mclk_cnt;
  localparam logic [sdpi_pkg::MCLK_CNT_W-1:0] MCLK_LAST =
    sdpi_pkg::MCLK_CNT_W'(sdpi_pkg::MCLK_HALF - 1);
  wire mclk_wrap = (mclk_cnt == MCLK_LAST);
  always_ff @(posedge clk) begin
    if (rst) begin
      mclk_cnt    <= '0;
      mem_clk_out <= 1'b0;
    end else if (ce) begin
      mclk_cnt <= mclk_wrap ? '0 : mclk_cnt + 1'b1;
      if (mclk_wrap) begin
        mem_clk_out <= ~mem_clk_out;
      end
    end
  end

  // Access sequencer; all logic here runs on the returned clock
  sdpi_pkg::sdpi_state_e state;
  sdpi_pkg::sdpi_state_e next_state;
  logic                            acc_write;
  logic [1:0]                      acc_chip;
  logic [1:0]                      acc_bank;
  logic [sdpi_pkg::ROW_W-1:0]      acc_row;
  logic [sdpi_pkg::ADDR_W-1:0]     acc_col;
  logic [sdpi_pkg::DATA_W-1:0]     acc_wdata;
  logic [sdpi_pkg::LANES-1:0]      acc_mask;
  logic                            buf_in_ready;

  wire take       = req_valid & req_ready;
  wire is_16m     = (density == sdpi_pkg::DENS_16M);
  wire is_4bank   = (density == sdpi_pkg::DENS_4BANK);
  wire rd_push    = (state == sdpi_pkg::ST_DATA) & ~acc_write;

  // A read waits before its row cycle until the buffer can take its word
  always_comb begin
    next_state = state;
    unique case (state)
      sdpi_pkg::ST_IDLE: begin
        if (take) begin
          next_state = (req_write || buf_in_ready) ? sdpi_pkg::ST_ROW : sdpi_pkg::ST_STALL;
        end
      end
      sdpi_pkg::ST_STALL: begin
        if (buf_in_ready) begin
          next_state = sdpi_pkg::ST_ROW;
        end
      end
      sdpi_pkg::ST_ROW:  next_state = sdpi_pkg::ST_COL;
      sdpi_pkg::ST_COL:  next_state = sdpi_pkg::ST_DATA;
      sdpi_pkg::ST_DATA: next_state = sdpi_pkg::ST_IDLE;
      default:           next_state = sdpi_pkg::ST_IDLE;
    endcase
  end

  // Chip select decode, used for the row and the column cycle alike
  function automatic logic [3:0] chip_dec(input logic [1:0] chip, input logic dens16);
    logic [3:0] sel;
    sel = 4'h0;
    sel[dens16 ? chip : {1'b0, chip[0]}] = 1'b1;
    return ~sel;
  endfunction

  // A row cycle launched at the take edge must see the new request, not the held one
  wire [1:0]                 cur_chip = take ? req_chip : acc_chip;
  wire [1:0]                 cur_bank = take ? req_bank : acc_bank;
  wire [sdpi_pkg::ROW_W-1:0] cur_row  = take ? req_row : acc_row;
  wire [3:0] cs_n_acc = chip_dec(cur_chip, is_16m);
  wire       is_row   = (next_state == sdpi_pkg::ST_ROW);
  wire       is_col   = (next_state == sdpi_pkg::ST_COL);
  wire       in_cmd   = is_row | is_col;
  // Address bit 11 and 12 only exist on the row; a column leaves them low, except pin 12 carries bank 1 in four-bank mode
  wire       pin11    = is_16m ? cs_n_acc[2] : (is_row & cur_row[sdpi_pkg::ROW_B11]);
  wire       pin12    = is_16m   ? cs_n_acc[3] :
                        is_4bank ? cur_bank[1] :
                        (is_row & cur_row[sdpi_pkg::ROW_B12]);
  wire [sdpi_pkg::ADDR_W-1:0] next_addr =
    is_row ? cur_row[sdpi_pkg::ADDR_W-1:0] : is_col ? acc_col : mem_addr;

  always_ff @(posedge clk) begin
    if (int_rst) begin
      state <= sdpi_pkg::ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Request capture; held values let the pins come from flip-flops
  always_ff @(posedge clk) begin
    if (int_rst) begin
      acc_write <= 1'b0;
      acc_chip  <= 2'h0;
      acc_bank  <= 2'h0;
      acc_row   <= '0;
      acc_col   <= sdpi_pkg::ADDR_RST;
      acc_wdata <= '0;
      acc_mask  <= '0;
      req_ready <= 1'b0;
    end else if (ce) begin
      req_ready <= (next_state == sdpi_pkg::ST_IDLE) & ~take;
      if (take) begin
        acc_write <= req_write;
        acc_chip  <= req_chip;
        acc_bank  <= req_bank;
        acc_row   <= req_row;
        acc_col   <= req_col;
        acc_wdata <= req_wdata;
        acc_mask  <= req_mask;
      end
    end
  end

  // Pin drivers: chips are deselected between accesses, except select 2, which stays low in 16-Mbit mode
  always_ff @(posedge clk) begin
    if (int_rst) begin
      mem_cs_n        <= 2'h3;
      mem_cs2_a11     <= 1'b1;
      mem_cs3_a12_ba1 <= 1'b1;
      mem_addr        <= sdpi_pkg::ADDR_RST;
      mem_ba0         <= 1'b0;
      mem_ras_n       <= 2'h3;
      mem_cas_n       <= 2'h3;
      mem_write_en_n  <= 1'b1;
      mem_mask        <= sdpi_pkg::MASK_IDLE;
      mem_data_o      <= '0;
      mem_data_oe     <= 1'b0;
    end else if (ce) begin
      mem_cs_n        <= in_cmd ? cs_n_acc[1:0] : 2'h3;
      mem_cs2_a11     <= in_cmd ? pin11 : ~is_16m;
      mem_cs3_a12_ba1 <= in_cmd ? pin12 : is_16m;
      mem_addr        <= next_addr;
      mem_ba0         <= cur_bank[0];
      mem_ras_n       <= {2{~is_row}};
      mem_cas_n       <= {2{~is_col}};
      mem_write_en_n  <= ~(is_col & acc_write);
      mem_mask        <= (is_col || next_state == sdpi_pkg::ST_DATA) ?
                         acc_mask : sdpi_pkg::MASK_IDLE;
      mem_data_o      <= acc_wdata;
      mem_data_oe     <= (next_state == sdpi_pkg::ST_DATA) & acc_write;
    end
  end

  // Read data passes a two-entry buffer so a stalled receiver drops nothing
  sdpi_buf #(
    .WIDTH (sdpi_pkg::DATA_W)
  ) u_rd_buf (
    .clk       (clk),
    .rst       (int_rst),
    .ce        (ce),
    .in_valid  (rd_push),
    .in_ready  (buf_in_ready),
    .in_data   (mem_data_i),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence row_cycle_s;
    (mem_ras_n == 2'h0) && (mem_cas_n == 2'h3);
  endsequence

  sequence col_cycle_s;
    (mem_cas_n == 2'h0) && (mem_ras_n == 2'h3);
  endsequence

  hard_reset_a: assert property ((sync2 && !sync3) |=> hard_reset)
    else $error("Hard reset pulse missing after reset release");

  strap_take_a: assert property ((sync2 && !sync3) |=> strap == $past(mem_data_i[40:0]))
    else $error("Straps did not take the data bus at release");

  strap_hold_a: assert property (!(sync2 && !sync3) |=> $stable(strap))
    else $error("Straps changed without a reset release");

  reset_out_a: assert property (!sync2 |=> !sys_reset_out_n)
    else $error("Reset output high while reset input low");

  row_col_a: assert property (row_cycle_s |=> col_cycle_s)
    else $error("Column strobe did not follow the row strobe");

  write_en_a: assert property (col_cycle_s |-> (mem_write_en_n == !acc_write))
    else $error("Write enable wrong for access direction");

  drive_after_a: assert property ((col_cycle_s and !mem_write_en_n)
                                  |=> mem_data_oe ##1 !mem_data_oe)
    else $error("Write data not driven for one cycle");

  shared_pin_a: assert property ((row_cycle_s and (!is_16m && density != 2'h2))
                                 |-> mem_cs3_a12_ba1 == acc_row[12])
    else $error("Address bit 12 wrong on row cycle");

  cs2_pin_a: assert property ((row_cycle_s and is_16m) |-> mem_cs2_a11 == cs_n_acc[2])
    else $error("Third chip select wrong in 16-Mbit mode");

  idle_mask_a: assert property ((state == sdpi_pkg::ST_IDLE) |-> mem_mask == 8'hff)
    else $error("Lanes unmasked while idle");

  clk_toggle_a: assert property (mclk_wrap |=> mem_clk_out != $past(mem_clk_out))
    else $error("Outgoing clock did not toggle");

  col_mask_a: assert property (col_cycle_s |-> mem_mask == acc_mask)
    else $error("Lane mask wrong on column cycle");

  row_addr_a: assert property (row_cycle_s |-> mem_addr == acc_row[10:0])
    else $error("Row address wrong on row cycle");

  col_addr_a: assert property (col_cycle_s |-> mem_addr == acc_col)
    else $error("Column address wrong on column cycle");

  bank_zero_a: assert property (row_cycle_s |-> mem_ba0 == acc_bank[0])
    else $error("Bank address 0 wrong on row cycle");

  idle_select_a: assert property ((state == sdpi_pkg::ST_IDLE) |-> mem_cs_n == 2'h3)
    else $error("Chip selected while idle");

  rd_room_a: assert property (rd_push |-> buf_in_ready)
    else $error("Read word pushed into a full buffer");

endmodule // sdpi_top

// [sdpi_dimm_mdl.sv]
`timescale 1ns/1ps
// Behavioural DIMM bank: stores words by the pin pattern seen at row and column strobes
module sdpi_dimm_mdl (
  input  wire logic        clk,       // Memory clock
  input  wire logic [1:0]  density,   // Fitted density
  input  wire logic [1:0]  cs_n,      // Chip selects 0 and 1
  input  wire logic        cs2,       // Shared pin 11
  input  wire logic        cs3,       // Shared pin 12
  input  wire logic [10:0] addr,      // Address lines
  input  wire logic        ba0,       // Bank 0
  input  wire logic [1:0]  ras_n,     // Row strobes
  input  wire logic [1:0]  cas_n,     // Column strobes
  input  wire logic        we_n,      // Write enable
  input  wire logic [7:0]  mask,      // Byte masks
  input  wire logic [63:0] d_in,      // Bus level
  input  wire logic        strap_en,  // Board straps drive the bus
  input  wire logic [40:0] strap_val, // Strap pattern
  output logic      [63:0] d_out      // Bus drive from this side
);
  logic [63:0] mem [logic [27:0]];
  logic [15:0] row_key;
  logic [27:0] key;
  logic        rd;
  logic        wr;
  logic [63:0] word;
  wire sel = (cs_n != 2'b11) || (density == 2'h0 && !(cs2 && cs3));
  // Strobe capture, data phase and bus drive
  always @(posedge clk) begin
    if (ras_n == 2'b00 && sel) row_key <= {cs_n, cs2, cs3, ba0, addr};
    if (wr) begin
      word = mem.exists(key) ? mem[key] : 64'h0;
      for (int l = 0; l < 8; l++) if (!mask[l]) word[l*8 +: 8] = d_in[l*8 +: 8];
      mem[key] = word;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    if (cas_n == 2'b00 && sel) begin
      key <= {row_key, addr, cs3};
      rd  <= we_n;
      wr  <= !we_n;
      word = mem.exists({row_key, addr, cs3}) ? mem[{row_key, addr, cs3}] : 64'h0;
      // Masked lanes float, so they show a changing pattern instead of data
      for (int l = 0; l < 8; l++) if (mask[l]) word[l*8 +: 8] = ~d_out[l*8 +: 8];
      if (we_n) d_out <= word;
      else d_out <= ~d_out;
    end else if (strap_en) d_out <= {23'h0, strap_val};
    else d_out <= ~d_out;
  end
endmodule // sdpi_dimm_mdl

// [tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk, rst, ce, sys_n, strap_en, rd_ready, req_valid, req_write;
  logic [1:0]  density, req_chip, req_bank, cs_n, ras_n, cas_n, ch_r, bk_r;
  logic [12:0] req_row, rw_r;
  logic [10:0] req_col, mem_addr, cl_r;
  logic [63:0] req_wdata, mdl_d, rdat, rd_data, d_o, w1, w2;
  logic [7:0]  req_mask, mem_mask, mk;
  logic [40:0] strap_val, strap;
  logic        rst_out, hard_reset, mclk, req_ready, rd_valid, cs2, cs3, ba0, we_n, d_oe, b;
  int          miscompares, checked, n;
  // Bus level: the controller wins while it drives, else the DIMM side
  wire [63:0] bus = d_oe ? d_o : mdl_d;
  sdpi_top i_dut (.clk(clk), .rst(rst), .ce(ce), .sys_reset_in_n(sys_n),
    .sys_reset_out_n(rst_out), .hard_reset(hard_reset), .strap(strap), .mem_clk_out(mclk),
    .density(density), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_chip(req_chip), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
    .req_wdata(req_wdata), .req_mask(req_mask), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .mem_cs_n(cs_n), .mem_cs2_a11(cs2), .mem_cs3_a12_ba1(cs3),
    .mem_addr(mem_addr), .mem_ba0(ba0), .mem_ras_n(ras_n), .mem_cas_n(cas_n),
    .mem_write_en_n(we_n), .mem_mask(mem_mask), .mem_data_i(bus), .mem_data_o(d_o),
    .mem_data_oe(d_oe));
  sdpi_dimm_mdl i_mdl (.clk(clk), .density(density), .cs_n(cs_n), .cs2(cs2), .cs3(cs3),
    .addr(mem_addr), .ba0(ba0), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mask(mem_mask),
    .d_in(bus), .strap_en(strap_en), .strap_val(strap_val), .d_out(mdl_d));
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Unmasked lanes take the second word, masked lanes keep the first
  function automatic logic [63:0] merge(input logic [63:0] a, c, input logic [7:0] m);
    for (int l = 0; l < 8; l++) if (!m[l]) a[l*8 +: 8] = c[l*8 +: 8];
    return a;
  endfunction
  // One access, pins checked in the row, column and data cycles
  task automatic access(input logic wr, input logic [1:0] ch, bk, input logic [12:0] rw,
                        input logic [10:0] cl, input logic [63:0] wd, input logic [7:0] m);
    int k;
    logic fb;
    logic [3:0] ecs;
    @(posedge clk);
    // Density set by the caller at the previous edge has settled by now
    fb = (density == sdpi_pkg::DENS_4BANK);
    ecs = ~(4'h1 << ch);
    {req_valid, req_write, req_chip, req_bank, req_row, req_col, req_wdata, req_mask}
      <= {1'b1, wr, ch, bk, rw, cl, wd, m};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (req_ready !== 1'b1 && k < 50);
    chk("req_ready", req_ready, 1'b1);
    req_valid <= 1'b0;
    @(posedge clk);
    chk("ras_n", ras_n, 2'b00);
    chk("row", mem_addr, rw[10:0]);
    chk("ba0", ba0, bk[0]);
    if (density == sdpi_pkg::DENS_16M) chk("cs", {cs3, cs2, cs_n}, ecs);
    else begin
      chk("cs_n", cs_n, ch[0] ? 2'b01 : 2'b10);
      chk("shared_r", {cs3, cs2}, {fb ? bk[1] : rw[12], rw[11]});
    end
    @(posedge clk);
    chk("cas_n", cas_n, 2'b00);
    chk("col", mem_addr, cl);
    chk("we_n", we_n, !wr);
    if (density != sdpi_pkg::DENS_16M) chk("shared_c", {cs3, cs2}, {fb & bk[1], 1'b0});
    if (wr) chk("mask", mem_mask, m);
    @(posedge clk);
    chk("oe", d_oe, wr);
    if (wr) chk("wdata", d_o, wd);
  endtask
  task automatic get_rd;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!(rd_valid === 1'b1 && rd_ready) && k < 50);
    chk("rd_valid", rd_valid, 1'b1);
    rdat = rd_data;
  endtask
  initial begin
    #60000;
    miscompares++;
    end_sim();
  end
  initial begin
    {rst, ce, sys_n, strap_en, rd_ready, req_valid, req_write} = 7'b1111100;
    {density, req_chip, req_bank, req_row, req_col, req_wdata, req_mask} = '0;
    strap_val = 41'h0;
    void'($urandom(32'hb1d7));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    sys_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("rst_out_low", rst_out, 1'b0);
    strap_val <= 41'({$urandom, $urandom});
    sys_n <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hard_reset !== 1'b1 && n < 10);
    // Two synchroniser flops, then the pulse flop, seen one edge later
    chk("hard_delay", n, 4);
    chk("strap", strap, strap_val);
    @(posedge clk);
    chk("hard_pulse", hard_reset, 1'b0);
    chk("rst_out_high", rst_out, 1'b1);
    strap_en <= 1'b0;
    repeat (8) @(posedge clk);
    chk("strap_hold", strap, strap_val);
    b = mclk;
    @(posedge clk);
    chk("mclk", mclk, !b);
    // Clock enable low freezes the divider
    ce <= 1'b0;
    @(posedge clk);
    b = mclk;
    repeat (3) @(posedge clk);
    chk("ce_hold", mclk, b);
    ce <= 1'b1;
    // Random traffic over every density code, corner masks and rows first
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      density <= 2'(i);
      w1 = {$urandom, $urandom};
      w2 = {$urandom, $urandom};
      mk = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      rw_r = (i == 2) ? 13'h1fff : 13'($urandom);
      cl_r = (i == 3) ? 11'h7ff : 11'($urandom);
      ch_r = 2'($urandom);
      bk_r = 2'($urandom);
      access(1'b1, ch_r, bk_r, rw_r, cl_r, w1, 8'h00);
      access(1'b1, ch_r, bk_r, rw_r, cl_r, w2, mk);
      access(1'b0, ch_r, bk_r, rw_r, cl_r, 64'h0, 8'h00);
      get_rd();
      chk("rd_data", rdat, merge(w1, w2, mk));
    end
    // Receiver stalls: two reads wait in the buffer, none lost
    access(1'b1, 2'h0, 2'h1, 13'h0012, 11'h034, w1, 8'h00);
    access(1'b1, 2'h1, 2'h2, 13'h0056, 11'h078, w2, 8'h00);
    rd_ready <= 1'b0;
    access(1'b0, 2'h0, 2'h1, 13'h0012, 11'h034, 64'h0, 8'h00);
    access(1'b0, 2'h1, 2'h2, 13'h0056, 11'h078, 64'h0, 8'h00);
    repeat (4) @(posedge clk);
    chk("rd_hold", rd_valid, 1'b1);
    rd_ready <= 1'b1;
    get_rd();
    chk("rd_first", rdat, w1);
    get_rd();
    chk("rd_second", rdat, w2);
    end_sim();
  end
endmodule // tb
